// File: rtl/clock_mode_cfg.svh
// register offsets, field positions, reset values and timing counts of the clock mode control block
`ifndef CLOCK_MODE_CFG_SVH
`define CLOCK_MODE_CFG_SVH

`define CLOCK_CONTROL_ONE_ADDR       4'h0
`define CLOCK_CONTROL_TWO_ADDR       4'h4
`define REFERENCE_PERIOD_ADJUST_ADDR 4'h8
`define CLOCK_STATUS_CONTROL_ADDR    4'hc

`define SOURCE_SELECT_BIT            6
`define REFERENCE_STOP_KEEP_BIT      0
`define BUS_DIVIDER_HI               7
`define BUS_DIVIDER_LO               6
`define LOW_POWER_SELECT_BIT         3
`define SOURCE_STATE_BIT             2
`define FINE_PERIOD_ADJUST_BIT       0

`define BUS_DIVIDER_RESET            2'h1
`define FLL_MULTIPLIER               512

`define CLOCK_PERIOD_PS              5000
`define REFERENCE_WAKEUP_TIME_NS     100
`define FLL_RECOVERY_TIME_NS         100
`define REFERENCE_WAKEUP_CYCLES      ((`REFERENCE_WAKEUP_TIME_NS * 1000 + `CLOCK_PERIOD_PS - 1) / `CLOCK_PERIOD_PS)
`define FLL_RECOVERY_CYCLES          ((`FLL_RECOVERY_TIME_NS * 1000 + `CLOCK_PERIOD_PS - 1) / `CLOCK_PERIOD_PS)

`define AXI_RESP_OKAY                2'h0
`define AXI_RESP_SLVERR              2'h2

`endif

// File: rtl/clock_mode_pkg.sv
// types shared by the clock mode control block
package clock_mode_pkg;
    typedef enum logic [1:0] {
        fll_engaged_mode,
        fll_bypassed_mode,
        bypassed_low_power_mode,
        stop_mode
    } mode_type;
endpackage : clock_mode_pkg

// File: rtl/delay_timer.sv
// loadable down counter that reports when a wait time has elapsed
`timescale 1ns/1ps
module delay_timer #(
    parameter int WIDTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             start,
    input  wire logic [WIDTH-1:0] cycles,
    output logic                  busy
);
    logic [WIDTH-1:0] count;

    if (WIDTH < 2) begin : width_check
        $error("delay_timer width too small");
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            count <= '0;
        end else if (start) begin
            count <= cycles;
        end else if (count != '0) begin
            count <= count - 1'b1;
        end
    end

    assign busy = (count != '0);
endmodule : delay_timer

// File: rtl/sync_two_flop.sv
// two flip-flop synchroniser for a level
`timescale 1ns/1ps
module sync_two_flop (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic d,
    output logic      q
);
    logic first;

    always_ff @(posedge clk) begin
        if (rst) begin
            first <= 1'b0;
            q     <= 1'b0;
        end else begin
            first <= d;
            q     <= first;
        end
    end
endmodule : sync_two_flop

// File: rtl/internal_clock_unit.sv
// clock mode control of the internal clock unit with an AXI4-Lite register slave
//
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "clock_mode_cfg.svh"
module internal_clock_unit #(
    parameter int TIMER_WIDTH = 16
) (
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        STOP_REQUEST,
    input  wire logic        WAKE_INTERRUPT,
    input  wire logic [3:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [3:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    output logic [1:0]       MODE,
    output logic             FLL_ENABLE,
    output logic             REFERENCE_ENABLE,
    output logic             SOURCE_IS_REFERENCE,
    output logic [8:0]       PERIOD_ADJUST,
    output logic             SYSTEM_CLOCK_ENABLE,
    output logic             BUS_CLOCK_ENABLE,
    output logic             CLOCK_VALID
);
    if (TIMER_WIDTH < 8) begin : timer_width_check
        $error("timer width cannot hold the wake delays");
    end

    // ==========================================================
    // registers
    logic        source_select;
    logic        reference_stop_keep;
    logic [1:0]  bus_divider_field;
    logic        low_power_select;
    logic [7:0]  reference_period_adjust;
    logic        fine_period_adjust;
    logic        source_state;
    logic        adjust_loaded;

    // ==========================================================
    // AXI4-Lite write channel
    logic [3:0]  aw_addr;
    logic        aw_held;
    logic [7:0]  w_byte;
    logic        w_lane;
    logic        w_held;
    logic        do_write;

    assign do_write = aw_held && w_held && !S_AXI_BVALID;

    always_ff @(posedge CLK) begin
        if (RST) begin
            aw_held       <= 1'b0;
            aw_addr       <= 4'h0;
            S_AXI_AWREADY <= 1'b1;
        end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_held       <= 1'b1;
            aw_addr       <= S_AXI_AWADDR;
            S_AXI_AWREADY <= 1'b0;
        end else if (do_write) begin
            aw_held       <= 1'b0;
        end else if (!aw_held && !S_AXI_BVALID) begin
            S_AXI_AWREADY <= 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            w_held       <= 1'b0;
            w_byte       <= 8'h00;
            w_lane       <= 1'b0;
            S_AXI_WREADY <= 1'b1;
        end else if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_held       <= 1'b1;
            w_byte       <= S_AXI_WDATA[7:0];
            w_lane       <= S_AXI_WSTRB[0];
            S_AXI_WREADY <= 1'b0;
        end else if (do_write) begin
            w_held       <= 1'b0;
        end else if (!w_held && !S_AXI_BVALID) begin
            S_AXI_WREADY <= 1'b1;
        end
    end

    logic write_mapped;
    assign write_mapped = (aw_addr == `CLOCK_CONTROL_ONE_ADDR) || (aw_addr == `CLOCK_CONTROL_TWO_ADDR) ||
                          (aw_addr == `REFERENCE_PERIOD_ADJUST_ADDR) || (aw_addr == `CLOCK_STATUS_CONTROL_ADDR);

    always_ff @(posedge CLK) begin
        if (RST) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= `AXI_RESP_OKAY;
        end else if (do_write) begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= write_mapped ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        end else if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
        end
    end

    // control fields return to defaults on reset
    always_ff @(posedge CLK) begin
        if (RST) begin
            source_select       <= 1'b0;
            reference_stop_keep <= 1'b0;
            bus_divider_field   <= `BUS_DIVIDER_RESET;
            low_power_select    <= 1'b0;
        end else if (do_write && w_lane) begin
            if (aw_addr == `CLOCK_CONTROL_ONE_ADDR) begin
                source_select       <= w_byte[`SOURCE_SELECT_BIT];
                reference_stop_keep <= w_byte[`REFERENCE_STOP_KEEP_BIT];
            end
            if (aw_addr == `CLOCK_CONTROL_TWO_ADDR) begin
                bus_divider_field   <= w_byte[`BUS_DIVIDER_HI:`BUS_DIVIDER_LO];
                low_power_select    <= w_byte[`LOW_POWER_SELECT_BIT];
            end
        end
    end

    // adjust values have no reset branch so they survive any reset
    always_ff @(posedge CLK) begin
        if (do_write && w_lane && aw_addr == `REFERENCE_PERIOD_ADJUST_ADDR) begin
            reference_period_adjust <= w_byte;
        end
        if (do_write && w_lane && aw_addr == `CLOCK_STATUS_CONTROL_ADDR) begin
            fine_period_adjust      <= w_byte[`FINE_PERIOD_ADJUST_BIT];
        end
    end

    // marks whether the adjust values were ever written, for a defined output
    always_ff @(posedge CLK) begin
        if (do_write && w_lane && (aw_addr == `REFERENCE_PERIOD_ADJUST_ADDR ||
                                   aw_addr == `CLOCK_STATUS_CONTROL_ADDR)) begin
            adjust_loaded <= 1'b1;
        end else if (adjust_loaded !== 1'b1) begin
            adjust_loaded <= 1'b0;
        end
    end

    // ==========================================================
    // AXI4-Lite read channel
    logic [7:0] read_byte;
    logic       read_mapped;

    always_comb begin
        read_byte   = 8'h00;
        read_mapped = 1'b1;
        unique case (S_AXI_ARADDR)
            `CLOCK_CONTROL_ONE_ADDR: begin
                read_byte[`SOURCE_SELECT_BIT]       = source_select;
                read_byte[`REFERENCE_STOP_KEEP_BIT] = reference_stop_keep;
            end
            `CLOCK_CONTROL_TWO_ADDR: begin
                read_byte[`BUS_DIVIDER_HI:`BUS_DIVIDER_LO] = bus_divider_field;
                read_byte[`LOW_POWER_SELECT_BIT]           = low_power_select;
            end
            `REFERENCE_PERIOD_ADJUST_ADDR: begin
                read_byte = adjust_loaded ? reference_period_adjust : 8'h00;
            end
            `CLOCK_STATUS_CONTROL_ADDR: begin
                read_byte[`SOURCE_STATE_BIT]       = source_state;
                read_byte[`FINE_PERIOD_ADJUST_BIT] = adjust_loaded ? fine_period_adjust : 1'b0;
            end
            default: begin
                read_mapped = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h0000_0000;
            S_AXI_RRESP   <= `AXI_RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b1;
            S_AXI_RDATA   <= {24'h00_0000, read_byte};
            S_AXI_RRESP   <= read_mapped ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID  <= 1'b0;
            S_AXI_ARREADY <= 1'b1;
        end
    end

    // ==========================================================
    // mode sequencing
    logic                   stop_sync;
    logic                   wake_sync;
    logic                   select_sync;
    logic                   timer_busy;
    logic                   timer_start;
    logic [TIMER_WIDTH-1:0] timer_cycles;
    clock_mode_pkg::mode_type mode;
    clock_mode_pkg::mode_type run_mode;
    clock_mode_pkg::mode_type prior_mode;

    sync_two_flop stop_sync_inst (
        .clk (CLK),
        .rst (RST),
        .d   (STOP_REQUEST),
        .q   (stop_sync)
    );

    sync_two_flop wake_sync_inst (
        .clk (CLK),
        .rst (RST),
        .d   (WAKE_INTERRUPT),
        .q   (wake_sync)
    );

    // source state lags the select by three cycles: a crossing-style two-stage path, then its status register
    sync_two_flop select_sync_inst (
        .clk (CLK),
        .rst (RST),
        .d   (source_select),
        .q   (select_sync)
    );

    always_comb begin
        if (!source_select) begin
            run_mode = clock_mode_pkg::fll_engaged_mode;
        end else if (low_power_select) begin
            run_mode = clock_mode_pkg::bypassed_low_power_mode;
        end else begin
            run_mode = clock_mode_pkg::fll_bypassed_mode;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            mode       <= clock_mode_pkg::fll_engaged_mode;
            prior_mode <= clock_mode_pkg::fll_engaged_mode;
        end else if (mode == clock_mode_pkg::stop_mode) begin
            if (wake_sync) begin
                mode <= prior_mode;
            end
        end else if (stop_sync) begin
            prior_mode <= run_mode;
            mode       <= clock_mode_pkg::stop_mode;
        end else begin
            mode <= run_mode;
        end
    end

    logic waking;
    assign waking      = (mode == clock_mode_pkg::stop_mode) && wake_sync;
    assign timer_start = waking && (!reference_stop_keep || prior_mode == clock_mode_pkg::fll_engaged_mode);
    assign timer_cycles = !reference_stop_keep ? TIMER_WIDTH'(`REFERENCE_WAKEUP_CYCLES)
                                               : TIMER_WIDTH'(`FLL_RECOVERY_CYCLES);

    delay_timer #(
        .WIDTH (TIMER_WIDTH)
    ) wake_timer_inst (
        .clk    (CLK),
        .rst    (RST),
        .start  (timer_start),
        .cycles (timer_cycles),
        .busy   (timer_busy)
    );

    // ==========================================================
    // divider chain: system enable then bus enable at half of it
    logic [2:0] divide_count;
    logic       system_tick;
    logic       bus_phase;

    always_comb begin
        unique case (bus_divider_field)
            2'h0:    system_tick = 1'b1;
            2'h1:    system_tick = (divide_count[0] == 1'b1);
            2'h2:    system_tick = (divide_count[1:0] == 2'h3);
            default: system_tick = (divide_count == 3'h7);
        endcase
    end

    logic clocks_run;
    assign clocks_run = (mode != clock_mode_pkg::stop_mode) && !timer_busy;

    always_ff @(posedge CLK) begin
        if (RST) begin
            divide_count        <= 3'h0;
            bus_phase           <= 1'b0;
            SYSTEM_CLOCK_ENABLE <= 1'b0;
            BUS_CLOCK_ENABLE    <= 1'b0;
        end else begin
            divide_count        <= clocks_run ? divide_count + 3'h1 : 3'h0;
            SYSTEM_CLOCK_ENABLE <= clocks_run && system_tick;
            if (clocks_run && system_tick) begin
                bus_phase <= ~bus_phase;
            end
            BUS_CLOCK_ENABLE    <= clocks_run && system_tick && bus_phase;
        end
    end

    // ==========================================================
    // status and outputs
    always_ff @(posedge CLK) begin
        if (RST) begin
            source_state        <= 1'b0;
            MODE                <= 2'h0;
            FLL_ENABLE          <= 1'b1;
            REFERENCE_ENABLE    <= 1'b1;
            SOURCE_IS_REFERENCE <= 1'b0;
            PERIOD_ADJUST       <= 9'h000;
            CLOCK_VALID         <= 1'b0;
        end else begin
            source_state        <= select_sync;
            MODE                <= mode;
            // the enabled loop runs at the fixed multiplier of the reference
            FLL_ENABLE          <= (mode == clock_mode_pkg::fll_engaged_mode) ||
                                   (mode == clock_mode_pkg::fll_bypassed_mode);
            REFERENCE_ENABLE    <= (mode != clock_mode_pkg::stop_mode) || reference_stop_keep;
            SOURCE_IS_REFERENCE <= select_sync;
            PERIOD_ADJUST       <= adjust_loaded ? {reference_period_adjust, fine_period_adjust} : 9'h000;
            CLOCK_VALID         <= clocks_run;
        end
    end
endmodule : internal_clock_unit

// File: bench/internal_clock_unit_properties.sv
// port assertions of the internal clock unit
`timescale 1ns/1ps
`include "clock_mode_cfg.svh"
module internal_clock_unit_properties (
    input wire logic        CLK,
    input wire logic        RST,
    input wire logic        S_AXI_AWVALID,
    input wire logic        S_AXI_AWREADY,
    input wire logic        S_AXI_WVALID,
    input wire logic        S_AXI_WREADY,
    input wire logic        S_AXI_BVALID,
    input wire logic        S_AXI_ARVALID,
    input wire logic        S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [1:0]  S_AXI_RRESP,
    input wire logic        S_AXI_RVALID,
    input wire logic [1:0]  MODE,
    input wire logic        FLL_ENABLE,
    input wire logic        REFERENCE_ENABLE,
    input wire logic        SYSTEM_CLOCK_ENABLE,
    input wire logic        BUS_CLOCK_ENABLE,
    input wire logic        CLOCK_VALID
);
    // ====================================================================
    // sequences
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    sequence write_taken;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    endsequence
    sequence read_taken;
        S_AXI_ARVALID && S_AXI_ARREADY;
    endsequence
    sequence stop_held;
        (MODE == 2'h3) [*2];
    endsequence
    // ====================================================================
    // assertions
    write_answer_a: assert property (write_taken |=> ##1 S_AXI_BVALID) else $error("write response late");
    read_answer_a: assert property (read_taken |=> S_AXI_RVALID) else $error("read response late");
    upper_zero_a: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0)
        else $error("unused read bits not zero");
    slverr_zero_a: assert property (S_AXI_RVALID && S_AXI_RRESP == `AXI_RESP_SLVERR |-> S_AXI_RDATA == 32'h0)
        else $error("refused read carries data");
    stop_halt_a: assert property (stop_held |-> !FLL_ENABLE && !SYSTEM_CLOCK_ENABLE)
        else $error("clocks running in stop");
    stop_invalid_a: assert property (stop_held |-> !CLOCK_VALID) else $error("clock valid in stop");
    lowpower_fll_a: assert property ((MODE == 2'h2) [*2] |-> !FLL_ENABLE)
        else $error("fll on in low power bypass");
    bypass_fll_a: assert property ((MODE == 2'h1) [*2] |-> FLL_ENABLE)
        else $error("fll off in bypass");
    ref_stop_a: assert property (!REFERENCE_ENABLE |-> MODE == 2'h3 || $past(MODE) == 2'h3)
        else $error("reference off outside stop");
    bus_half_a: assert property (BUS_CLOCK_ENABLE |-> SYSTEM_CLOCK_ENABLE)
        else $error("bus pulse without system pulse");
endmodule : internal_clock_unit_properties

bind internal_clock_unit internal_clock_unit_properties u_internal_clock_unit_properties (
    .CLK(CLK), .RST(RST), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
    .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID), .MODE(MODE), .FLL_ENABLE(FLL_ENABLE),
    .REFERENCE_ENABLE(REFERENCE_ENABLE), .SYSTEM_CLOCK_ENABLE(SYSTEM_CLOCK_ENABLE),
    .BUS_CLOCK_ENABLE(BUS_CLOCK_ENABLE), .CLOCK_VALID(CLOCK_VALID));

// File: bench/internal_clock_unit_tb.sv
// self-checking bench of the internal clock unit
`timescale 1ns/1ps
`include "clock_mode_cfg.svh"
module internal_clock_unit_tb;
    // ====================================================================
    // signals
    logic        clk      = 1'b0;
    logic        rst      = 1'b1;
    logic        stop_req = 1'b0;
    logic        wake     = 1'b0;
    logic [3:0]  awaddr   = 4'h0;
    logic [3:0]  araddr   = 4'h0;
    logic [3:0]  wstrb    = 4'hf;
    logic [31:0] wdata    = 32'h0;
    logic        awvalid  = 1'b0;
    logic        wvalid   = 1'b0;
    logic        bready   = 1'b0;
    logic        arvalid  = 1'b0;
    logic        rready   = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, mode;
    logic [31:0] rdata;
    logic [8:0]  period;
    logic        fll_en, ref_en, src_ref, sys_en, bus_en, valid;
    logic [33:0] notes[$];
    logic [31:0] seed     = 32'h3c069f0f;
    int          error_cnt = 0;
    int          compares  = 0;
    int          cs, cb;

    initial begin
        forever #2.5 clk = ~clk;
    end

    internal_clock_unit #(.TIMER_WIDTH(16)) u_internal_clock_unit (
        .CLK(clk), .RST(rst), .STOP_REQUEST(stop_req), .WAKE_INTERRUPT(wake),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .MODE(mode), .FLL_ENABLE(fll_en), .REFERENCE_ENABLE(ref_en),
        .SOURCE_IS_REFERENCE(src_ref), .PERIOD_ADJUST(period), .SYSTEM_CLOCK_ENABLE(sys_en),
        .BUS_CLOCK_ENABLE(bus_en), .CLOCK_VALID(valid));

    // ====================================================================
    // tasks
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift

    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize;
        if (error_cnt == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize

    task automatic give_up;
        error_cnt++;
        summarize();
    endtask : give_up

    task automatic tick(input int c);
        repeat (c) @(posedge clk);
    endtask : tick

    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] resp);
        int k;
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        notes.push_back({resp, 32'h0});
        k = 0;
        do begin
            @(posedge clk);
            k++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready) && k < 100);
        bready <= 1'b0;
        if (k >= 100) give_up();
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] resp);
        int k;
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        notes.push_back({resp, d});
        k = 0;
        do begin
            @(posedge clk);
            k++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && rready) && k < 100);
        rready <= 1'b0;
        if (k >= 100) give_up();
    endtask : rd

    task automatic stop_wake(input logic keep_ref, input logic [1:0] prior);
        int k;
        stop_req <= 1'b1;
        tick(8);
        check(34'(mode), 34'(clock_mode_pkg::stop_mode));
        check({31'h0, ref_en, fll_en, valid}, {31'h0, keep_ref, 2'b00});
        stop_req <= 1'b0;
        wake     <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (valid !== 1'b1 && k < 80);
        wake <= 1'b0;
        if (k >= 80) give_up();
        check(34'(mode), 34'(prior));
        if (!keep_ref) begin
            check(34'(k >= `REFERENCE_WAKEUP_CYCLES), 34'h1);
        end else if (prior == 2'(clock_mode_pkg::fll_engaged_mode)) begin
            check(34'(k >= `FLL_RECOVERY_CYCLES), 34'h1);
        end else begin
            check(34'(k < `FLL_RECOVERY_CYCLES), 34'h1);
        end
    endtask : stop_wake

    // ====================================================================
    // response watcher and main sequence
    always @(posedge clk) begin
        if ((bvalid && bready) || (rvalid && rready)) begin
            if (notes.size() == 0) give_up();
            else if (bvalid && bready) check({bresp, 32'h0}, notes.pop_front());
            else check({rresp, rdata}, notes.pop_front());
        end
    end

    initial begin
        tick(20);
        rst <= 1'b0;
        tick(2);
        check({32'h0, mode}, 34'(clock_mode_pkg::fll_engaged_mode));
        rd(`CLOCK_CONTROL_TWO_ADDR, 32'h40, `AXI_RESP_OKAY);
        wr(`CLOCK_CONTROL_TWO_ADDR, 32'hff, `AXI_RESP_OKAY);
        rd(`CLOCK_CONTROL_TWO_ADDR, 32'hc8, `AXI_RESP_OKAY);
        wr(`CLOCK_CONTROL_ONE_ADDR, 32'hff, `AXI_RESP_OKAY);
        rd(`CLOCK_CONTROL_ONE_ADDR, 32'h41, `AXI_RESP_OKAY);
        check({32'h0, mode}, 34'(clock_mode_pkg::bypassed_low_power_mode));
        wr(`CLOCK_STATUS_CONTROL_ADDR, 32'hfa, `AXI_RESP_OKAY);
        rd(`CLOCK_STATUS_CONTROL_ADDR, 32'h04, `AXI_RESP_OKAY);
        check({33'h0, period[0]}, 34'h0);
        wr(`CLOCK_CONTROL_TWO_ADDR, 32'h40, `AXI_RESP_OKAY);
        tick(2);
        check({31'h0, mode, fll_en}, {31'h0, 2'(clock_mode_pkg::fll_bypassed_mode), 1'b1});
        wr(`CLOCK_CONTROL_TWO_ADDR, 32'h48, `AXI_RESP_OKAY);
        wr(`CLOCK_CONTROL_ONE_ADDR, 32'h01, `AXI_RESP_OKAY);
        check({33'h0, src_ref}, 34'h1);
        tick(5);
        check({31'h0, mode, src_ref}, {31'h0, 2'(clock_mode_pkg::fll_engaged_mode), 1'b0});
        for (int c = 0; c < 4; c++) begin
            wr(`CLOCK_CONTROL_TWO_ADDR, 32'(c) << 6, `AXI_RESP_OKAY);
            tick(3);
            cs = 0;
            cb = 0;
            repeat (64) begin
                @(posedge clk);
                cs += int'(sys_en === 1'b1);
                cb += int'(bus_en === 1'b1);
            end
            check(34'(cs), 34'(64 >> c));
            check(34'(cb), 34'(32 >> c));
        end
        for (int i = 0; i < 4; i++) begin
            seed = xorshift(seed);
            wr(`REFERENCE_PERIOD_ADJUST_ADDR, {24'h0, seed[7:0]}, `AXI_RESP_OKAY);
            rd(`REFERENCE_PERIOD_ADJUST_ADDR, {24'h0, seed[7:0]}, `AXI_RESP_OKAY);
            check({26'h0, period[8:1]}, {26'h0, seed[7:0]});
        end
        wr(`CLOCK_STATUS_CONTROL_ADDR, 32'h01, `AXI_RESP_OKAY);
        tick(1);
        check({33'h0, period[0]}, 34'h1);
        wstrb <= 4'h0;
        wr(`REFERENCE_PERIOD_ADJUST_ADDR, ~seed, `AXI_RESP_OKAY);
        wstrb <= 4'hf;
        rd(`REFERENCE_PERIOD_ADJUST_ADDR, {24'h0, seed[7:0]}, `AXI_RESP_OKAY);
        wr(4'h6, 32'hff, `AXI_RESP_SLVERR);
        rd(4'h6, 32'h0, `AXI_RESP_SLVERR);
        wr(`CLOCK_CONTROL_TWO_ADDR, 32'h40, `AXI_RESP_OKAY);
        wr(`CLOCK_CONTROL_ONE_ADDR, 32'h41, `AXI_RESP_OKAY);
        tick(4);
        stop_wake(1'b1, 2'(clock_mode_pkg::fll_bypassed_mode));
        wr(`CLOCK_CONTROL_ONE_ADDR, 32'h01, `AXI_RESP_OKAY);
        tick(4);
        stop_wake(1'b1, 2'(clock_mode_pkg::fll_engaged_mode));
        wr(`CLOCK_CONTROL_TWO_ADDR, 32'h48, `AXI_RESP_OKAY);
        wr(`CLOCK_CONTROL_ONE_ADDR, 32'h40, `AXI_RESP_OKAY);
        tick(4);
        stop_wake(1'b0, 2'(clock_mode_pkg::bypassed_low_power_mode));
        stop_req <= 1'b1;
        tick(8);
        rst      <= 1'b1;
        stop_req <= 1'b0;
        tick(3);
        rst <= 1'b0;
        tick(2);
        check({32'h0, mode}, 34'(clock_mode_pkg::fll_engaged_mode));
        check({25'h0, period}, {25'h0, seed[7:0], 1'b1});
        rd(`CLOCK_CONTROL_TWO_ADDR, 32'h40, `AXI_RESP_OKAY);
        // let the watcher compare the last answer before the verdict
        tick(2);
        summarize();
    end
endmodule : internal_clock_unit_tb
